// file: hw/stop_mode_wake_clock_control.sv
// Stop-mode reference keep and ring-oscillator wake clock control
// Contract
// - Keep bit set keeps reference on in stop
// - Keep bit resets 0, reference off in stop
// - Keep bit ignored outside stop mode
// - Kept reference lets supply drop wake stop
// - Crystal oscillator halted throughout stop mode
// - Ring select plus interrupt resumes within 100ns
// - Count 65536 external cycles, then switch back
// - Ring select resets 0, wake waits crystal
// - Power-fail interrupt vectors 0033h, top priority
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module stop_mode_wake_clock_control
	import stop_wake_pkg::*;
#(
	parameter int unsigned EXT_COUNT = EXT_COUNT_LEN
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// Register port
	input wire reg_req_t i_bus,
	output logic [7:0] o_rdata,
	output logic o_irq,
	// Power control
	input wire logic i_stop_req,
	input wire logic i_wake_irq,
	input wire logic i_ext_tick,
	input wire logic i_ref_normal_en,
	input wire logic i_supply_low,
	input wire logic i_pfi_enable,
	// Clock and reference controls
	output logic o_ref_enable,
	output logic o_xtal_enable,
	output logic o_clk_ring_sel,
	output logic o_resume,
	output logic o_ring_osc_active_flag,
	// Power-fail outputs
	output logic o_pf_reset,
	output logic o_pf_irq,
	output logic [15:0] o_pf_vector,
	output logic o_pf_top_priority
);
	typedef struct packed {
		mode_t mode;
		logic keep;
		logic ring_sel;
		logic flag;
		logic ref_en;
		logic xtal_en;
		logic clk_ring;
		logic resume;
		logic pf_reset;
		logic pf_irq;
		logic supply_q;
		logic [NUM_EV-1:0] status;
		logic [NUM_EV-1:0] enable;
		logic [7:0] rdata;
		logic irq;
		logic [15:0] vector;
		logic top_prio;
	} ctl_state_t;

	localparam int RESUME_LIM = RESUME_CYC;

	ctl_state_t s_ff;
	ctl_state_t nxt_s;
	logic cnt_done;
	logic cnt_clear;
	logic pf_edge;
	logic [NUM_EV-1:0] ev;
	logic [NUM_EV-1:0] clr_mask;

	assign cnt_clear = (s_ff.mode != ST_XTAL_WAIT) && (s_ff.mode != ST_RING);

	ext_cycle_counter #(
		.LIMIT(EXT_COUNT)
	) u_counter (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_clear(cnt_clear),
		.i_tick(i_ext_tick),
		.o_done(cnt_done)
	);

	always_comb begin
		nxt_s = s_ff;
		ev = '0;
		clr_mask = '0;
		nxt_s.resume = 1'b0;
		nxt_s.pf_reset = 1'b0;
		nxt_s.pf_irq = 1'b0;
		nxt_s.supply_q = i_supply_low;
		// Supply drop seen only while the reference is powered
		pf_edge = s_ff.ref_en && i_supply_low && !s_ff.supply_q;
		if (pf_edge) begin
			ev[EV_POWER_FAIL] = 1'b1;
			if (i_pfi_enable) begin
				nxt_s.pf_irq = 1'b1;
			end else begin
				nxt_s.pf_reset = 1'b1;
			end
		end
		case (s_ff.mode)
			ST_RUN: begin
				if (i_stop_req) begin
					nxt_s.mode = ST_STOP;
				end
			end
			ST_STOP: begin
				if (pf_edge && !i_pfi_enable) begin
					nxt_s.mode = ST_RUN;
				end else if (i_wake_irq || (pf_edge && i_pfi_enable)) begin
					if (s_ff.ring_sel) begin
						nxt_s.mode = ST_RING;
						nxt_s.clk_ring = 1'b1;
						nxt_s.resume = 1'b1;
						nxt_s.flag = 1'b1;
						ev[EV_RING_WAKE] = 1'b1;
					end else begin
						nxt_s.mode = ST_XTAL_WAIT;
					end
				end
			end
			ST_XTAL_WAIT: begin
				if (cnt_done) begin
					nxt_s.mode = ST_RUN;
					nxt_s.resume = 1'b1;
				end
			end
			ST_RING: begin
				if (cnt_done) begin
					nxt_s.mode = ST_RUN;
					nxt_s.clk_ring = 1'b0;
					nxt_s.flag = 1'b0;
					ev[EV_SWITCH_BACK] = 1'b1;
				end
			end
			default: begin
				nxt_s.mode = ST_RUN;
			end
		endcase
		if (nxt_s.mode == ST_STOP) begin
			nxt_s.ref_en = s_ff.keep;
		end else begin
			nxt_s.ref_en = i_ref_normal_en;
		end
		nxt_s.xtal_en = (nxt_s.mode != ST_STOP);
		nxt_s.rdata = 8'h00;
		if (i_bus.wr) begin
			case (i_bus.addr)
				OFS_CTRL: begin
					nxt_s.keep = i_bus.wdata[BIT_KEEP];
					nxt_s.ring_sel = i_bus.wdata[BIT_RING_SEL];
				end
				OFS_INT_ENABLE: begin
					nxt_s.enable = i_bus.wdata[NUM_EV-1:0];
				end
				OFS_INT_CLEAR: begin
					clr_mask = i_bus.wdata[NUM_EV-1:0];
				end
				default: begin
				end
			endcase
		end
		if (i_bus.rd) begin
			case (i_bus.addr)
				OFS_CTRL: begin
					nxt_s.rdata[BIT_KEEP] = s_ff.keep;
					nxt_s.rdata[BIT_RING_SEL] = s_ff.ring_sel;
					nxt_s.rdata[BIT_RING_FLAG] = s_ff.flag;
				end
				OFS_INT_STATUS: begin
					nxt_s.rdata[NUM_EV-1:0] = s_ff.status;
				end
				OFS_INT_ENABLE: begin
					nxt_s.rdata[NUM_EV-1:0] = s_ff.enable;
				end
				default: begin
				end
			endcase
		end
		// A new event wins over a clear in the same cycle
		nxt_s.status = (s_ff.status & ~clr_mask) | ev;
		nxt_s.irq = |(nxt_s.status & nxt_s.enable);
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			s_ff <= '0;
			s_ff.mode <= ST_RUN;
			s_ff.keep <= RST_KEEP;
			s_ff.ring_sel <= RST_RING_SEL;
			s_ff.enable <= RST_INT_ENABLE;
			s_ff.xtal_en <= 1'b1;
			s_ff.vector <= PF_VECTOR;
			s_ff.top_prio <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign o_rdata = s_ff.rdata;
	assign o_irq = s_ff.irq;
	assign o_ref_enable = s_ff.ref_en;
	assign o_xtal_enable = s_ff.xtal_en;
	assign o_clk_ring_sel = s_ff.clk_ring;
	assign o_resume = s_ff.resume;
	assign o_ring_osc_active_flag = s_ff.flag;
	assign o_pf_reset = s_ff.pf_reset;
	assign o_pf_irq = s_ff.pf_irq;
	assign o_pf_vector = s_ff.vector;
	assign o_pf_top_priority = s_ff.top_prio;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	AST_KEEP_ON: assert property (
		(s_ff.mode == ST_STOP && $past(s_ff.keep) && s_ff.keep)
		|-> s_ff.ref_en)
		else $error("Reference off in stop with keep set");
	AST_KEEP_OFF: assert property (
		(s_ff.mode == ST_STOP && $past(s_ff.keep) == 1'b0)
		|-> !s_ff.ref_en)
		else $error("Reference on in stop with keep clear");
	AST_NORMAL_REF: assert property (
		(s_ff.mode != ST_STOP) |-> s_ff.ref_en == $past(i_ref_normal_en))
		else $error("Reference not under normal control");
	AST_PF_WAKE: assert property (
		(s_ff.mode == ST_STOP && s_ff.ref_en && i_supply_low
		&& !s_ff.supply_q && !i_pfi_enable)
		|=> o_pf_reset && s_ff.mode == ST_RUN)
		else $error("Supply drop did not wake stop");
	AST_XTAL_HALT: assert property (
		(s_ff.mode == ST_STOP) |-> !o_xtal_enable)
		else $error("Crystal running in stop");
	AST_RING_RESUME: assert property (
		(s_ff.mode == ST_STOP && s_ff.ring_sel && i_wake_irq
		&& !(s_ff.ref_en && i_supply_low && !s_ff.supply_q && !i_pfi_enable))
		|-> ##[1:RESUME_LIM] (o_resume && o_clk_ring_sel))
		else $error("Ring wake too slow");
	AST_SWITCH_BACK: assert property (
		$fell(o_clk_ring_sel) |-> $past(cnt_done) && !o_ring_osc_active_flag
		&& s_ff.status[EV_SWITCH_BACK])
		else $error("Switchback without full count");
	AST_XTAL_WAKE: assert property (
		(s_ff.mode == ST_STOP && !s_ff.ring_sel && i_wake_irq
		&& !(s_ff.ref_en && i_supply_low && !s_ff.supply_q))
		|=> s_ff.mode == ST_XTAL_WAIT && !o_clk_ring_sel ##1 !o_resume)
		else $error("Non-ring wake used ring");
	AST_PF_VECTOR: assert property (
		o_pf_irq |-> o_pf_vector == 16'h0033 && o_pf_top_priority)
		else $error("Power-fail vector wrong");
	AST_FLAG_SET: assert property (
		$rose(o_ring_osc_active_flag) |-> o_resume && o_clk_ring_sel)
		else $error("Ring flag rose without resume");
	AST_RING_EVENT: assert property (
		$rose(o_clk_ring_sel) |-> s_ff.status[EV_RING_WAKE])
		else $error("Ring wake not logged in status");
	AST_RESUME_PULSE: assert property (
		o_resume |=> !o_resume)
		else $error("Resume pulse longer than one cycle");
	AST_XTAL_RUN: assert property (
		(s_ff.mode == ST_RUN) |-> o_xtal_enable)
		else $error("Crystal stopped while running");
	AST_RING_HOLD: assert property (
		(s_ff.mode == ST_RING) |-> o_clk_ring_sel && o_ring_osc_active_flag)
		else $error("Ring clock or flag dropped before count end");
	AST_XTAL_NO_RING: assert property (
		(s_ff.mode == ST_XTAL_WAIT) |-> !o_clk_ring_sel)
		else $error("Ring clock used while waiting for crystal");
	// No supply event can be seen with the reference powered down
	AST_PF_GATED: assert property (
		!s_ff.ref_en |=> !o_pf_irq && !o_pf_reset)
		else $error("Power-fail event with reference off");
	AST_IRQ_LEVEL: assert property (
		o_irq == |(s_ff.status & s_ff.enable))
		else $error("Interrupt line disagrees with status");

	CV_RING_WAKE: cover property (
		s_ff.mode == ST_STOP ##1 s_ff.mode == ST_RING);
	CV_SWITCH: cover property ($fell(o_ring_osc_active_flag));
	CV_PF_STOP: cover property (s_ff.mode == ST_STOP && o_pf_irq);
	CV_XTAL_WAKE: cover property (
		s_ff.mode == ST_XTAL_WAIT ##1 s_ff.mode == ST_RUN);
endmodule

// file: hw/stop_wake_pkg.sv
// Shared constants and types of the stop-mode wake clock control
package stop_wake_pkg;
	// Register offsets (byte addresses)
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_INT_STATUS = 4'h4;
	localparam logic [3:0] OFS_INT_ENABLE = 4'h8;
	localparam logic [3:0] OFS_INT_CLEAR = 4'hc;
	// Control register fields
	localparam int BIT_KEEP = 0;
	localparam int BIT_RING_SEL = 1;
	localparam int BIT_RING_FLAG = 2;
	// Interrupt status fields
	localparam int EV_RING_WAKE = 0;
	localparam int EV_SWITCH_BACK = 1;
	localparam int EV_POWER_FAIL = 2;
	localparam int NUM_EV = 3;
	// Reset values
	localparam logic RST_KEEP = 1'b0;
	localparam logic RST_RING_SEL = 1'b0;
	localparam logic [NUM_EV-1:0] RST_INT_ENABLE = 3'h0;
	// Timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int RESUME_NS = 100;
	localparam int RESUME_CYC = (RESUME_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned EXT_COUNT_LEN = 65536;
	localparam int CNT_W = 17;
	// Power-fail interrupt vector
	localparam logic [15:0] PF_VECTOR = 16'h0033;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_STOP,
		ST_XTAL_WAIT,
		ST_RING
	} mode_t;
endpackage

// file: hw/ext_cycle_counter.sv
// Counter of external crystal cycles with a sticky done flag
`timescale 1ns/1ps
module ext_cycle_counter
	import stop_wake_pkg::*;
#(
	parameter int unsigned LIMIT = EXT_COUNT_LEN
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// Control
	input wire logic i_clear,
	input wire logic i_tick,
	// Result
	output logic o_done
);
	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic done;
	} cnt_state_t;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

	cnt_state_t cs_ff;
	cnt_state_t nxt_cs;

	always_comb begin
		nxt_cs = cs_ff;
		if (i_clear) begin
			nxt_cs.count = '0;
			nxt_cs.done = 1'b0;
		end else if (i_tick && !cs_ff.done) begin
			// Done on the last external cycle of the window
			if (cs_ff.count == LAST) begin
				nxt_cs.done = 1'b1;
			end
			nxt_cs.count = cs_ff.count + 1'b1;
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			cs_ff <= '0;
		end else begin
			cs_ff <= nxt_cs;
		end
	end

	assign o_done = cs_ff.done;
endmodule

// file: dv/stop_mode_wake_clock_control_tb.sv
// Register-task bench for the stop-mode wake clock control
`timescale 1ns/1ps
module stop_mode_wake_clock_control_tb
	import stop_wake_pkg::*;
;
	logic i_mclk, i_reset, stop, wake, tick, ref_n, low, pfi_en;
	reg_req_t bus;
	logic [7:0] rdata;
	logic irq, ref_en, xtal, ring, resume, flag, pfr, power_fail_interrupt, top;
	logic [15:0] vec;
	int err_count, checks, n_res, n_pfi, n_pfr;

	// Shortened crystal count keeps the run brief
	stop_mode_wake_clock_control #(.EXT_COUNT(8)) dut (
		.i_mclk(i_mclk), .i_reset(i_reset), .i_bus(bus), .o_rdata(rdata),
		.o_irq(irq), .i_stop_req(stop), .i_wake_irq(wake),
		.i_ext_tick(tick), .i_ref_normal_en(ref_n), .i_supply_low(low),
		.i_pfi_enable(pfi_en), .o_ref_enable(ref_en), .o_xtal_enable(xtal),
		.o_clk_ring_sel(ring), .o_resume(resume),
		.o_ring_osc_active_flag(flag), .o_pf_reset(pfr), .o_pf_irq(power_fail_interrupt),
		.o_pf_vector(vec), .o_pf_top_priority(top));

	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end

	// Pulse counters for one-cycle outputs
	always @(posedge i_mclk) begin
		if (resume === 1'b1) n_res++;
		if (power_fail_interrupt === 1'b1) n_pfi++;
		if (pfr === 1'b1) n_pfr++;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge i_mclk);
		bus <= '0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge i_mclk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge i_mclk);
		bus <= '0;
		#1;
		chk(16'(rdata), 16'(exp));
	endtask

	// Selector: 0 stop request, 1 wake interrupt, else crystal tick
	task automatic pulse(input int which, input int n);
		repeat (n) begin
			@(posedge i_mclk);
			case (which)
				0: stop <= 1'b1;
				1: wake <= 1'b1;
				default: tick <= 1'b1;
			endcase
			@(posedge i_mclk);
			{stop, wake, tick} <= 3'h0;
		end
		#1;
	endtask

	task automatic tally_and_finish();
		if (err_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end

	initial begin
		{stop, wake, tick, ref_n, low, pfi_en} = '0;
		bus = '0;
		i_reset = 1'b1;
		repeat (3) @(posedge i_mclk);
		i_reset <= 1'b0;
		step(1);
		chk(16'(xtal), 16'h0001);
		chk(vec, 16'h0033);
		chk(16'(top), 16'h0001);
		rd(OFS_CTRL, 8'h00);
		rd(4'h2, 8'h00);
		// Keep bit set while running leaves normal control in charge
		wr(OFS_CTRL, 8'h01);
		step(2);
		chk(16'(ref_en), 16'h0000);
		ref_n <= 1'b1;
		step(2);
		chk(16'(ref_en), 16'h0001);
		pfi_en <= 1'b1;
		low <= 1'b1;
		step(3);
		chk(16'(n_pfi), 16'h0001);
		low <= 1'b0;
		// Reference off in stop without the keep bit
		wr(OFS_CTRL, 8'h00);
		pulse(0, 1);
		step(1);
		chk(16'(ref_en), 16'h0000);
		chk(16'(xtal), 16'h0000);
		low <= 1'b1;
		step(3);
		chk(16'(n_pfi), 16'h0001);
		low <= 1'b0;
		// Plain wake waits for the crystal count
		pulse(1, 1);
		step(3);
		chk(16'(n_res), 16'h0000);
		chk(16'(ring), 16'h0000);
		pulse(2, 8);
		step(3);
		chk(16'(n_res), 16'h0001);
		chk(16'(xtal), 16'h0001);
		// Kept reference: supply drop resets out of stop
		wr(OFS_CTRL, 8'h01);
		pfi_en <= 1'b0;
		pulse(0, 1);
		step(1);
		chk(16'(ref_en), 16'h0001);
		low <= 1'b1;
		step(3);
		chk(16'(n_pfr), 16'h0001);
		low <= 1'b0;
		// Ring wake, count, switchback and interrupts
		rd(OFS_INT_STATUS, 8'h04);
		wr(OFS_INT_ENABLE, 8'h07);
		wr(OFS_INT_CLEAR, 8'h07);
		wr(OFS_CTRL, 8'h03);
		pulse(0, 1);
		step(1);
		chk(16'(xtal), 16'h0000);
		@(posedge i_mclk);
		wake <= 1'b1;
		@(posedge i_mclk);
		wake <= 1'b0;
		#1;
		chk(16'(resume), 16'h0001);
		chk(16'(ring), 16'h0001);
		chk(16'(flag), 16'h0001);
		rd(OFS_CTRL, 8'h07);
		rd(OFS_INT_STATUS, 8'h01);
		step(2);
		chk(16'(irq), 16'h0001);
		wr(OFS_INT_ENABLE, 8'h00);
		step(2);
		chk(16'(irq), 16'h0000);
		wr(OFS_INT_ENABLE, 8'h07);
		pulse(2, 7);
		step(3);
		chk(16'(flag), 16'h0001);
		pulse(2, 1);
		step(3);
		chk(16'(flag), 16'h0000);
		chk(16'(ring), 16'h0000);
		rd(OFS_CTRL, 8'h03);
		rd(OFS_INT_STATUS, 8'h03);
		wr(OFS_INT_CLEAR, 8'h03);
		rd(OFS_INT_STATUS, 8'h00);
		step(2);
		chk(16'(irq), 16'h0000);
		rd(OFS_INT_CLEAR, 8'h00);
		tally_and_finish();
	end
endmodule
